// ### hw/ssp_pkg.sv
// Purpose: shared constants and types of the two-wire slave serial port
// Assumes: 100 MHz system clock, APB register access
// Notes:   one 32-bit aligned word per register, data in the low byte
package ssp_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFS_MODE     = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_DATA     = 8'h0c;
    localparam logic [7:0] OFS_TIMEOUT  = 8'h10;

    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'he0;
    localparam logic [7:0] RST_STATUS   = 8'h81;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_TIMEOUT  = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MODE_OP_LSB  = 5;
    localparam int MODE_UART    = 4;
    localparam int MODE_DEB_LSB = 2;
    localparam int MODE_EN      = 1;
    localparam int ST_DONE      = 7;
    localparam int ST_MATCH     = 6;
    localparam int ST_BUSY      = 5;
    localparam int ST_TX_SEL    = 4;
    localparam int ST_ACK_OUT   = 3;
    localparam int ST_MRD       = 2;
    localparam int ST_WAKE_EN   = 1;
    localparam int ST_ACK_IN    = 0;
    localparam int TO_EN        = 7;
    localparam int TO_FLAG      = 6;

    // ****************************************************************
    // operating mode codes
    // ****************************************************************
    localparam logic [2:0] OP_SPI_SLAVE = 3'h5;
    localparam logic [2:0] OP_I2C_SLAVE = 3'h6;
    localparam logic [2:0] OP_UNUSED    = 3'h7;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int DEB_NONE = 0;
    localparam int DEB_TWO  = 2;
    localparam int DEB_FOUR = 4;
    localparam longint SYS_CLK_HZ = 64'd100000000;
    localparam longint SUB_CLK_HZ = 64'd32768;
    localparam longint TOUT_DIV   = 64'd32;
    localparam int TOUT_TICK_CYC  = int'(SYS_CLK_HZ * TOUT_DIV / SUB_CLK_HZ);
    localparam int TICK_W         = 17;
    localparam int BITS_PER_BYTE  = 8;

    // ****************************************************************
    // slave sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        SSP_IDLE    = 3'h0,
        SSP_ADDR    = 3'h1,
        SSP_AACK    = 3'h3,
        SSP_STRETCH = 3'h2,
        SSP_RX      = 3'h6,
        SSP_RACK    = 3'h7,
        SSP_TX      = 3'h5,
        SSP_TACK    = 3'h4
    } ssp_state_t;

endpackage

// ### hw/ssp_i2c_slave.sv
// Purpose: two-wire slave side of the shared serial unit with APB registers
// Assumes: external bus master, open-drain lines pulled high outside
// Notes:   both lines are released and the sequencer idles unless enabled
//
// What this block does
// - own address sits in bits 7..1; bit 0 is kept and read back.
// - device is selected when received address equals stored seven bits.
// - mode field 000-100 spi master, 101 spi slave, 110 two-wire, 111 unused.
// - uart-mode bit set selects uart; mode field acts only when it is low.
// - debounce field 00 none, 01 two clocks, 1x four clocks.
// - enable low releases both lines and stops the logic.
// - enable rising keeps tx and ack-out bits, defaults the status flags.
// - done flag low while shifting, high with interrupt after eight data bits.
// - match flag high on address equality, low otherwise.
// - busy flag set on start, cleared on stop.
// - tx-select one means transmitter, zero means receiver.
// - after eight received bits ack-out bit is driven on ninth clock.
// - eighth bit after address is captured as the master read flag.
// - wake-up enable lets an address match wake the system.
// - after eight sent bits master acknowledge sampled on ninth clock.
// - transmitter continues while acknowledged, releases data line on nack.
// - address arrives most significant bit first and is shifted so.
// - address match sets match flag and raises the shared interrupt.
// - a matched address is acknowledged low on the ninth bit.
// - clock held low after match until data write or dummy read.
// - time-out starts on match, restarts on clock fall, stops on stop.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

module ssp_i2c_slave import ssp_pkg::*; #(
    parameter int TICK_CYC = TOUT_TICK_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic             irq_o,
    output logic             wake_o,
    output logic             if_active_o
);

    // ****************************************************************
    // line synchroniser and debounce
    // ****************************************************************
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [1:0] filt;
    logic [1:0] fprev;
    logic [2:0] dcnt      [2];
    logic [1:0] next_lvl;
    logic [1:0] next_filt;
    logic [2:0] next_dcnt [2];
    logic [2:0] deb_len;

    function automatic logic [2:0] deb_cycles(input logic [1:0] sel);
        if (sel[1]) begin
            return 3'(DEB_FOUR);
        end else if (sel[0]) begin
            return 3'(DEB_TWO);
        end
        return 3'(DEB_NONE);
    endfunction

    logic [7:0] mode_ctrl;

    always_comb begin
        deb_len = deb_cycles(mode_ctrl[MODE_DEB_LSB +: 2]);
        for (int i = 0; i < 2; i++) begin
            next_lvl[i]  = (s2[i] == s3[i]) ? s3[i] : lvl[i];
            next_filt[i] = filt[i];
            next_dcnt[i] = 3'h0;
            if (lvl[i] != filt[i]) begin
                if (dcnt[i] >= deb_len) begin
                    next_filt[i] = lvl[i];
                end else begin
                    next_dcnt[i] = dcnt[i] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1    <= 2'h3;
            s2    <= 2'h3;
            s3    <= 2'h3;
            lvl   <= 2'h3;
            filt  <= 2'h3;
            fprev <= 2'h3;
            dcnt  <= '{3'h0, 3'h0};
        end else if (ce_i) begin
            s1    <= {sda_i, scl_i};
            s2    <= s1;
            s3    <= s2;
            lvl   <= next_lvl;
            filt  <= next_filt;
            fprev <= filt;
            dcnt  <= next_dcnt;
        end
    end

    // bit 0 is the clock line, bit 1 the data line
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = filt[0] & ~fprev[0];
    assign scl_fall = ~filt[0] & fprev[0];
    assign start_ev = filt[0] & fprev[0] & fprev[1] & ~filt[1];
    assign stop_ev  = filt[0] & fprev[0] & ~fprev[1] & filt[1];

    // ****************************************************************
    // registers, bus slave, sequencer and time-out
    // ****************************************************************
    logic [7:0]        own_addr;
    logic [7:0]        data_reg;
    logic [7:0]        to_ctrl;
    logic [7:0]        status;
    ssp_state_t        state;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic              en_d;
    logic              to_run;
    logic [TICK_W-1:0] tick_cnt;
    logic [5:0]        per_cnt;
    logic [7:0]        next_own_addr;
    logic [7:0]        next_mode_ctrl;
    logic [7:0]        next_data_reg;
    logic [7:0]        next_to_ctrl;
    logic [7:0]        next_status;
    ssp_state_t        next_state;
    logic [3:0]        next_cnt;
    logic [7:0]        next_sh;
    logic              next_to_run;
    logic [TICK_W-1:0] next_tick_cnt;
    logic [5:0]        next_per_cnt;
    logic              next_pready;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              next_scl_oe;
    logic              next_sda_oe;
    logic              next_irq;
    logic              next_wake;
    logic              i2c_mode;
    logic              active;
    logic              wr_ev;
    logic              rd_ev;
    logic              hit;
    logic [7:0]        rd_val;

    // two-wire only when uart bit low and mode code selects it
    assign i2c_mode = ~mode_ctrl[MODE_UART] &
                      (mode_ctrl[MODE_OP_LSB +: 3] == OP_I2C_SLAVE);
    assign active   = i2c_mode & mode_ctrl[MODE_EN];
    assign wr_ev    = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
    assign rd_ev    = psel_i & penable_i & pready_o & ~pwrite_i;

    always_comb begin
        next_own_addr  = own_addr;
        next_mode_ctrl = mode_ctrl;
        next_data_reg  = data_reg;
        next_to_ctrl   = to_ctrl;
        next_status    = status;
        next_state     = state;
        next_cnt       = cnt;
        next_sh        = sh;
        next_to_run    = to_run;
        next_tick_cnt  = tick_cnt;
        next_per_cnt   = per_cnt;
        next_scl_oe    = scl_oe_o;
        next_sda_oe    = sda_oe_o;
        next_irq       = 1'b0;
        next_wake      = wake_o & status[ST_WAKE_EN];
        next_pready    = psel_i & penable_i & ~pready_o;
        next_prdata    = prdata_o;
        next_pslverr   = pslverr_o;
        hit            = 1'b1;
        case (paddr_i)
            OFS_OWN_ADDR: rd_val = own_addr;
            OFS_MODE:     rd_val = mode_ctrl;
            OFS_STATUS:   rd_val = status;
            OFS_DATA:     rd_val = data_reg;
            OFS_TIMEOUT:  rd_val = to_ctrl;
            default: begin
                rd_val = 8'h00;
                hit    = 1'b0;
            end
        endcase
        if (next_pready) begin
            next_prdata  = {24'h000000, rd_val};
            next_pslverr = ~hit;
        end

        // software writes first so that hardware events below win
        if (wr_ev) begin
            case (paddr_i)
                OFS_OWN_ADDR: next_own_addr = pwdata_i[7:0];
                OFS_MODE:     next_mode_ctrl = pwdata_i[7:0];
                OFS_STATUS: begin
                    next_status[ST_TX_SEL]  = pwdata_i[ST_TX_SEL];
                    next_status[ST_ACK_OUT] = pwdata_i[ST_ACK_OUT];
                    next_status[ST_WAKE_EN] = pwdata_i[ST_WAKE_EN];
                end
                OFS_DATA:     next_data_reg = pwdata_i[7:0];
                OFS_TIMEOUT:  next_to_ctrl = pwdata_i[7:0];
                default: begin
                end
            endcase
        end

        // enable rising: flags to default, tx and ack-out kept
        if (i2c_mode & mode_ctrl[MODE_EN] & ~en_d) begin
            next_status[ST_DONE]   = 1'b1;
            next_status[ST_MATCH]  = 1'b0;
            next_status[ST_BUSY]   = 1'b0;
            next_status[ST_MRD]    = 1'b0;
            next_status[ST_ACK_IN] = 1'b1;
        end

        if (!active) begin
            next_state  = SSP_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_to_run = 1'b0;
            next_cnt    = 4'h0;
        end else if (stop_ev) begin
            next_status[ST_BUSY] = 1'b0;
            next_state  = SSP_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_to_run = 1'b0;
        end else if (start_ev) begin
            next_status[ST_BUSY] = 1'b1;
            next_state  = SSP_ADDR;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                SSP_ADDR, SSP_RX: begin
                    if (scl_rise) begin
                        next_sh  = {sh[6:0], filt[1]};
                        next_cnt = cnt + 4'h1;
                        next_status[ST_DONE] = 1'b0;
                        if (state == SSP_ADDR && cnt == 4'(BITS_PER_BYTE - 1)) begin
                            // only the seven upper bits are compared
                            if (sh[6:0] == own_addr[7:1]) begin
                                next_status[ST_MATCH] = 1'b1;
                                next_status[ST_MRD]   = filt[1];
                                next_irq    = 1'b1;
                                next_wake   = status[ST_WAKE_EN];
                                next_to_run = 1'b1;
                            end else begin
                                next_status[ST_MATCH] = 1'b0;
                            end
                        end
                    end else if (scl_fall && cnt == 4'(BITS_PER_BYTE)) begin
                        if (state == SSP_ADDR) begin
                            next_sda_oe = status[ST_MATCH];
                            next_state  = status[ST_MATCH] ? SSP_AACK : SSP_IDLE;
                        end else begin
                            next_data_reg = sh;
                            next_status[ST_DONE] = 1'b1;
                            next_irq    = 1'b1;
                            next_sda_oe = ~status[ST_ACK_OUT];
                            next_state  = SSP_RACK;
                        end
                    end
                end
                SSP_AACK, SSP_RACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_scl_oe = 1'b1;
                        next_state  = SSP_STRETCH;
                    end
                end
                SSP_STRETCH: begin
                    if (wr_ev && paddr_i == OFS_DATA && status[ST_TX_SEL]) begin
                        next_sh     = pwdata_i[7:0];
                        next_sda_oe = ~pwdata_i[7];
                        next_scl_oe = 1'b0;
                        next_cnt    = 4'h0;
                        next_status[ST_DONE] = 1'b0;
                        next_state  = SSP_TX;
                    end else if (rd_ev && paddr_i == OFS_DATA && !status[ST_TX_SEL]) begin
                        next_scl_oe = 1'b0;
                        next_cnt    = 4'h0;
                        next_status[ST_DONE] = 1'b0;
                        next_state  = SSP_RX;
                    end
                end
                SSP_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == 4'(BITS_PER_BYTE)) begin
                            next_sda_oe = 1'b0;
                            next_state  = SSP_TACK;
                        end else begin
                            next_sda_oe = ~sh[3'(4'h7 - cnt)];
                        end
                    end
                end
                SSP_TACK: begin
                    if (scl_rise) begin
                        next_status[ST_ACK_IN] = filt[1];
                        next_status[ST_DONE]   = 1'b1;
                        next_irq = 1'b1;
                    end else if (scl_fall) begin
                        // nack leaves the data line free for the stop
                        next_scl_oe = ~status[ST_ACK_IN];
                        next_state  = status[ST_ACK_IN] ? SSP_IDLE : SSP_STRETCH;
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                    next_scl_oe = 1'b0;
                end
            endcase
        end

        // time-out: ticks of 32 sub clock periods, cleared by clock falls
        if (active && to_run && to_ctrl[TO_EN]) begin
            if (scl_fall) begin
                next_tick_cnt = '0;
                next_per_cnt  = 6'h0;
            end else if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
                next_tick_cnt = '0;
                next_per_cnt  = per_cnt + 6'h1;
                if (per_cnt == to_ctrl[5:0]) begin
                    next_to_ctrl[TO_FLAG] = 1'b1;
                    next_to_ctrl[TO_EN]   = 1'b0;
                    next_status = RST_STATUS;
                    next_state  = SSP_IDLE;
                    next_scl_oe = 1'b0;
                    next_sda_oe = 1'b0;
                    next_to_run = 1'b0;
                    next_irq    = 1'b1;
                end
            end else begin
                next_tick_cnt = tick_cnt + TICK_W'(1);
            end
        end else begin
            next_tick_cnt = '0;
            next_per_cnt  = 6'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            own_addr    <= RST_OWN_ADDR;
            mode_ctrl   <= RST_MODE;
            data_reg    <= RST_DATA;
            to_ctrl     <= RST_TIMEOUT;
            status      <= RST_STATUS;
            state       <= SSP_IDLE;
            cnt         <= 4'h0;
            sh          <= 8'h00;
            en_d        <= 1'b0;
            to_run      <= 1'b0;
            tick_cnt    <= '0;
            per_cnt     <= 6'h0;
            pready_o    <= 1'b0;
            prdata_o    <= 32'h00000000;
            pslverr_o   <= 1'b0;
            scl_oe_o    <= 1'b0;
            sda_oe_o    <= 1'b0;
            irq_o       <= 1'b0;
            wake_o      <= 1'b0;
            if_active_o <= 1'b0;
        end else if (ce_i) begin
            own_addr    <= next_own_addr;
            mode_ctrl   <= next_mode_ctrl;
            data_reg    <= next_data_reg;
            to_ctrl     <= next_to_ctrl;
            status      <= next_status;
            state       <= next_state;
            cnt         <= next_cnt;
            sh          <= next_sh;
            en_d        <= i2c_mode & mode_ctrl[MODE_EN];
            to_run      <= next_to_run;
            tick_cnt    <= next_tick_cnt;
            per_cnt     <= next_per_cnt;
            pready_o    <= next_pready;
            prdata_o    <= next_prdata;
            pslverr_o   <= next_pslverr;
            scl_oe_o    <= next_scl_oe;
            sda_oe_o    <= next_sda_oe;
            irq_o       <= next_irq;
            wake_o      <= next_wake;
            if_active_o <= active;
        end
    end

    // open-drain lines only ever pull low
    always_ff @(posedge clk_i) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

endmodule

// ### verification/ssp_i2c_slave_checker.sv
// Purpose: concurrent checks on the ports of the two-wire slave
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into every slave instance
`timescale 1ns/10ps
module ssp_i2c_slave_checker import ssp_pkg::*; #(
    parameter int TICK_CYC = TOUT_TICK_CYC
) (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] prdata_o,
    input wire logic        scl_i,
    input wire logic        scl_oe_o,
    input wire logic        sda_oe_o,
    input wire logic        irq_o,
    input wire logic        wake_o,
    input wire logic        if_active_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence apb_commit;
        psel_i && penable_i && pready_o;
    endsequence
    sequence idle_two;
        !if_active_o [*2];
    endsequence
    chk_pready_pulse: assert property (apb_commit |=> !pready_o)
        else $error("pready held too long");
    chk_err_zero: assert property (apb_commit ##0 pslverr_o |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    chk_idle_release: assert property (idle_two |-> !scl_oe_o && !sda_oe_o)
        else $error("line driven while inactive");
    chk_drive_active: assert property ($rose(sda_oe_o) || $rose(scl_oe_o) |-> if_active_o)
        else $error("line driven while inactive");
    chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    chk_irq_pulse: assert property (irq_o |=> !irq_o)
        else $error("irq longer than one cycle");
    // a stretch ends only through a register access or a time-out
    chk_stretch_free: assert property ($fell(scl_oe_o) |->
        $past(pready_o) || $past(pready_o, 2) || irq_o || $past(irq_o))
        else $error("clock released without cause");
    chk_wake_cause: assert property ($rose(wake_o) |->
        irq_o || $past(irq_o) || $past(irq_o, 2))
        else $error("wake without address match");
endmodule

bind ssp_i2c_slave ssp_i2c_slave_checker #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .prdata_o,
    .scl_i, .scl_oe_o, .sda_oe_o, .irq_o, .wake_o, .if_active_o
);

// ### verification/ssp_i2c_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: lines pulled high outside, this model only pulls low
// Notes:   half bit lasts HP clocks; waits out clock stretching
`timescale 1ns/10ps
module ssp_i2c_master #(
    parameter int HP = 20
) (
    input  wire logic clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    initial scl_oe_o = 1'b0;
    initial sda_oe_o = 1'b0;
    task automatic hp;
        repeat (HP) @(posedge clk_i);
    endtask
    // the slave may hold the clock low
    task automatic rise;
        scl_oe_o <= 1'b0;
        do @(posedge clk_i); while (scl_i !== 1'b1);
        hp;
    endtask
    task automatic start;
        @(posedge clk_i);
        sda_oe_o <= 1'b0;
        hp;
        rise;
        sda_oe_o <= 1'b1;
        hp;
        scl_oe_o <= 1'b1;
        hp;
    endtask
    task automatic stop;
        @(posedge clk_i);
        sda_oe_o <= 1'b1;
        hp;
        rise;
        sda_oe_o <= 1'b0;
        hp;
    endtask
    task automatic clk_bit(input logic b, output logic s);
        @(posedge clk_i);
        sda_oe_o <= !b;
        hp;
        rise;
        s = sda_i;
        scl_oe_o <= 1'b1;
        hp;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] s,
                        output logic r);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s[i]);
        clk_bit(a, r);
    endtask
endmodule

// ### verification/ssp_i2c_slave_test.sv
// Purpose: self-checking bench of the two-wire slave port
// Assumes: master model on the bus, bench drives APB
// Notes:   time-out tick shortened to TK cycles
`timescale 1ns/10ps
module ssp_i2c_slave_test import ssp_pkg::*;;
    localparam int TK = 4;
    logic        clk_i, srst_i, psel, penable, pwrite, pready, pslverr;
    logic        scl_oe, sda_oe, m_scl, m_sda, irq, wake, act, r, err;
    logic [7:0]  paddr, q, d, md;
    logic [6:0]  ad;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          irqs = 0;
    logic [7:0]  rxq[$];
    logic [7:0]  rv[5] = '{RST_OWN_ADDR, RST_MODE, RST_STATUS, RST_DATA, RST_TIMEOUT};
    wire         scl = !(scl_oe || m_scl);
    wire         sda = !(sda_oe || m_sda);

    ssp_i2c_slave #(.TICK_CYC(TK)) dut (
        .clk_i, .srst_i, .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .scl_i(scl),
        .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .irq_o(irq), .wake_o(wake), .if_active_o(act)
    );
    ssp_i2c_master m (.clk_i, .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, v};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        irqs <= irqs + (irq === 1'b1);
        if (cyc == 60000) begin
            miscompares++;
            complete_run;
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        srst_i = 1'b1;
        void'($urandom(25172));
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (rv[i]) begin
            rd(8'(4 * i));
            chk(q, rv[i]);
        end
        rd(8'h14);
        chk({err, q}, 9'h100);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, OFS_MODE, {4'(i), 4'h2});
            repeat (2) @(negedge clk_i);
            chk(act, i == 12);
        end
        ad = 7'($urandom_range(127));
        md = {OP_I2C_SLAVE, 1'b0, 2'($urandom), 2'b10};
        apb(1'b1, OFS_MODE, md);
        apb(1'b1, OFS_OWN_ADDR, {ad, 1'b1});
        pstrb <= 4'he;
        apb(1'b1, OFS_OWN_ADDR, 8'h00);
        pstrb <= 4'hf;
        rd(OFS_OWN_ADDR);
        chk(q, {ad, 1'b1});
        // master writes two bytes, the second refused with ack_out
        apb(1'b1, OFS_STATUS, 8'h02);
        m.start;
        m.xfer({ad, 1'b0}, 1'b1, q, r);
        chk(r, 1'b0);
        chk(wake, 1'b1);
        rd(OFS_STATUS);
        chk(q & 8'h66, 8'h62);
        chk(scl_oe, 1'b1);
        rd(OFS_DATA);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            rxq.push_back(d);
            apb(1'b1, OFS_STATUS, {4'h0, k[0], 3'h2});
            m.xfer(d, 1'b1, q, r);
            chk(r, k[0]);
            rd(OFS_STATUS);
            chk(q[7], 1'b1);
            rd(OFS_DATA);
            chk(q, rxq.pop_front());
        end
        m.stop;
        rd(OFS_STATUS);
        chk(q[5], 1'b0);
        apb(1'b1, OFS_STATUS, 8'h00);
        repeat (2) @(negedge clk_i);
        chk(wake, 1'b0);
        // master reads two bytes, acking the first only
        m.start;
        m.xfer({ad, 1'b1}, 1'b1, q, r);
        rd(OFS_STATUS);
        chk(q[2], 1'b1);
        apb(1'b1, OFS_STATUS, 8'h10);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            apb(1'b1, OFS_DATA, d);
            m.xfer(8'hff, k[0], q, r);
            chk(q, d);
            rd(OFS_STATUS);
            chk({q[7], q[0]}, {1'b1, k[0]});
        end
        chk({scl_oe, sda_oe}, 2'b00);
        m.stop;
        m.start;
        m.xfer({ad ^ 7'h01, 1'b0}, 1'b1, q, r);
        chk(r, 1'b1);
        rd(OFS_STATUS);
        chk(q[6], 1'b0);
        m.stop;
        apb(1'b1, OFS_STATUS, 8'h18);
        apb(1'b1, OFS_MODE, md & 8'hfd);
        apb(1'b1, OFS_MODE, md);
        rd(OFS_STATUS);
        chk(q, 8'h99);
        // clock left stretched until the longest time-out runs out
        apb(1'b1, OFS_STATUS, 8'h00);
        apb(1'b1, OFS_TIMEOUT, 8'hbf);
        m.start;
        m.xfer({ad, 1'b0}, 1'b1, q, r);
        repeat (64 * TK + 40) @(posedge clk_i);
        rd(OFS_TIMEOUT);
        chk(q, 8'h7f);
        rd(OFS_STATUS);
        chk({scl_oe, q}, {1'b0, RST_STATUS});
        m.stop;
        chk(irqs, 8);
        complete_run;
    end
endmodule
